/* rtl/qenc_pkg.sv */
`default_nettype none

package qenc_pkg;

   // ****************************************
   // Line indices on the connector
   // ****************************************
   localparam int NUM_LINES = 6;
   localparam logic [2:0] IO_PIN_ONE = 3'h0;
   localparam logic [2:0] IO_PIN_TWO = 3'h1;
   localparam logic [2:0] IO_PIN_THREE = 3'h2;
   localparam logic [2:0] IO_PIN_FOUR = 3'h3;
   localparam logic [2:0] IO_PIN_FIVE = 3'h4;
   localparam logic [2:0] IO_PIN_SIX = 3'h5;

   // ****************************************
   // Configuration encodings
   // ****************************************
   localparam logic POSITION_MODE = 1'h0;
   localparam logic MOTION_MODE = 1'h1;
   localparam logic MUL_THEN_DIV = 1'h0;
   localparam logic DIV_THEN_MUL = 1'h1;
   localparam logic FWD_CLOCKWISE = 1'h0;
   localparam logic FWD_COUNTER_CLOCKWISE = 1'h1;
   localparam logic A_FROM_PIN_ONE = 1'h0;
   localparam logic A_FROM_PIN_THREE = 1'h1;
   localparam logic [1:0] B_UNUSED = 2'h0;
   localparam logic [1:0] B_FROM_PIN_TWO = 2'h1;
   localparam logic [1:0] B_FROM_PIN_FOUR = 2'h2;
   localparam logic EDGE_UP_ONLY = 1'h0;
   localparam logic EDGE_BOTH = 1'h1;
   localparam logic LINE_IS_INPUT = 1'h1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic PULSE_RST = 1'h0;
   localparam logic [1:0] SYNC_RST = 2'h0;
   localparam logic FWD_RST = 1'h1;

endpackage : qenc_pkg

`default_nettype wire

/* rtl/pulse_rate_scaler.sv */
`timescale 1ns/1ps
`default_nettype none

module pulse_rate_scaler #(
   parameter int FW = 8,
   parameter int PW = 16
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic pulse_in,
   input wire logic [FW-1:0] pulse_rate_mul_factor,
   input wire logic [FW-1:0] pulse_rate_div_factor,
   input wire logic scale_order_select,
   output logic pulse_out
);

   // ****************************************
   // Stage order
   // ****************************************
   logic mul_in;
   logic div_in;
   logic mul_out_q;
   logic div_out_q;
   logic div_first;

   assign div_first = (scale_order_select == qenc_pkg::DIV_THEN_MUL);
   assign mul_in = div_first ? div_out_q : pulse_in; // R05
   assign div_in = div_first ? pulse_in : mul_out_q; // R05
   assign pulse_out = div_first ? mul_out_q : div_out_q; // R05

   // ****************************************
   // Multiplier: each input adds factor pulses to a queue
   // ****************************************
   logic [FW-1:0] mul_eff;
   logic [PW:0] pend_sum;
   logic [PW-1:0] pend_q;

   assign mul_eff = (pulse_rate_mul_factor == '0) ? FW'(1) : pulse_rate_mul_factor;
   assign pend_sum = {1'h0, pend_q} + (mul_in ? (PW+1)'(mul_eff) : '0)
                     - (PW+1)'(pend_q != '0);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_q <= '0;
         mul_out_q <= qenc_pkg::PULSE_RST;
      end else begin
         // Saturate rather than wrap when pulses arrive too fast
         pend_q <= pend_sum[PW] ? '1 : pend_sum[PW-1:0]; // R06
         mul_out_q <= (pend_q != '0); // R06
      end
   end

   // ****************************************
   // Divider: one pulse out per factor pulses in
   // ****************************************
   logic [FW-1:0] div_eff;
   logic [FW-1:0] div_cnt_q;
   logic div_hit;

   assign div_eff = (pulse_rate_div_factor == '0) ? FW'(1) : pulse_rate_div_factor;
   assign div_hit = (div_cnt_q >= div_eff - FW'(1));

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_q <= '0;
         div_out_q <= qenc_pkg::PULSE_RST;
      end else begin
         div_out_q <= div_in & div_hit; // R07
         if (div_in) begin
            div_cnt_q <= div_hit ? '0 : div_cnt_q + FW'(1); // R07
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   mul_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
      mul_in && pend_q == '0 ##1 !mul_in |=> mul_out_q ##1 (mul_out_q == (mul_eff > FW'(1))))
      else $error("multiplier did not emit its pulses");

   div_pass_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
      div_in && div_eff == FW'(1) |=> div_out_q)
      else $error("divide by one dropped a pulse");

endmodule : pulse_rate_scaler

`default_nettype wire

/* rtl/quadrature_encoder_trigger_rescaler.sv */
// Notes on behaviour
// R01: Output mode input chooses when a valid encoder pulse is produced.
// R02: Position mode pulses on each new increment in forward direction.
// R03: Position mode, after reversal, pulses stay off until reversal point is passed.
// R04: Motion mode pulses on every increment in either direction.
// R05: Order select picks multiply-then-divide or divide-then-multiply.
// R06: Pulse rate is multiplied by a programmable factor.
// R07: Pulse rate is divided by a programmable factor.
// R08: Clockwise setting: forward when phase B leads phase A.
// R09: Counter-clockwise setting: forward when phase A leads phase B.
// R10: Phase A comes from pin one or pin three.
// R11: Phase B comes from pin two or pin four, or is unused.
// R12: Software sets a source line to input before using it as a phase.
// R13: Rising-edge setting counts only rising edges.
// R14: Both-edge setting counts rising and falling edges.
// R15: Line index selects one of six lines for line status access.
// R16: Without phase B, every counted phase A edge is forward.
// R17: Phases are synchronised before edge detection, giving one-cycle steps.
`timescale 1ns/1ps
`default_nettype none

module quadrature_encoder_trigger_rescaler #(
   parameter int FW = 8,
   parameter int PW = 16,
   parameter int BW = 16
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [qenc_pkg::NUM_LINES-1:0] io_line_in,
   input wire logic [qenc_pkg::NUM_LINES-1:0] io_line_direction,
   input wire logic [2:0] io_line_index,
   input wire logic enc_pulse_condition_select,
   input wire logic scale_order_select,
   input wire logic [FW-1:0] pulse_rate_mul_factor,
   input wire logic [FW-1:0] pulse_rate_div_factor,
   input wire logic forward_phase_select,
   input wire logic phase_a_line_select,
   input wire logic [1:0] phase_b_line_select,
   input wire logic count_edge_select,
   output logic trigger_pulse,
   output logic enc_pulse,
   output logic enc_forward,
   output logic [BW-1:0] backlog_count,
   output logic line_level_sel,
   output logic line_is_input_sel
);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   // ****************************************
   // Phase source selection
   // ****************************************
   logic a_raw;
   logic b_raw;
   logic b_used;

   always_comb begin
      // A line not set to input contributes a steady low level
      if (phase_a_line_select == qenc_pkg::A_FROM_PIN_THREE) begin
         a_raw = io_line_in[qenc_pkg::IO_PIN_THREE] // R10
                 & io_line_direction[qenc_pkg::IO_PIN_THREE]; // R12
      end else begin
         a_raw = io_line_in[qenc_pkg::IO_PIN_ONE] // R10
                 & io_line_direction[qenc_pkg::IO_PIN_ONE]; // R12
      end
      unique case (phase_b_line_select)
         qenc_pkg::B_FROM_PIN_TWO: begin
            b_raw = io_line_in[qenc_pkg::IO_PIN_TWO] & io_line_direction[qenc_pkg::IO_PIN_TWO]; // R11
            b_used = 1'h1;
         end
         qenc_pkg::B_FROM_PIN_FOUR: begin
            b_raw = io_line_in[qenc_pkg::IO_PIN_FOUR] & io_line_direction[qenc_pkg::IO_PIN_FOUR]; // R11
            b_used = 1'h1;
         end
         default: begin
            b_raw = 1'h0; // R11
            b_used = 1'h0;
         end
      endcase
   end

   // ****************************************
   // Synchronisers and edge detection
   // ****************************************
   logic [1:0] a_sync_q;
   logic [1:0] b_sync_q;
   logic a_s;
   logic b_s;
   logic a_d_q;
   logic b_d_q;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         a_sync_q <= qenc_pkg::SYNC_RST;
         b_sync_q <= qenc_pkg::SYNC_RST;
         a_d_q <= qenc_pkg::PULSE_RST;
         b_d_q <= qenc_pkg::PULSE_RST;
      end else begin
         a_sync_q <= {a_sync_q[0], a_raw}; // R17
         b_sync_q <= {b_sync_q[0], b_raw}; // R17
         a_d_q <= a_s;
         b_d_q <= b_s;
      end
   end

   assign a_s = a_sync_q[1];
   assign b_s = b_sync_q[1];

   logic a_rise;
   logic a_edge;
   logic b_edge;
   logic step_valid;
   logic b_leads;
   logic step_fwd;

   assign a_rise = a_s & ~a_d_q;
   assign a_edge = a_s ^ a_d_q;
   assign b_edge = b_used & (b_s ^ b_d_q);

   always_comb begin
      // In both-edge mode, both phases moving in one cycle carries no direction; it is dropped
      if (count_edge_select == qenc_pkg::EDGE_BOTH) begin
         step_valid = (a_edge | b_edge) & ~(a_edge & b_edge); // R14
      end else begin
         step_valid = a_rise; // R13
      end
   end

   // Old A against new B tells which phase moved first
   assign b_leads = a_d_q ^ b_s;

   always_comb begin
      if (!b_used) begin
         step_fwd = 1'h1; // R16
      end else if (forward_phase_select == qenc_pkg::FWD_COUNTER_CLOCKWISE) begin
         step_fwd = ~b_leads; // R09
      end else begin
         step_fwd = b_leads; // R08
      end
   end

   // ****************************************
   // Position tracking and pulse condition
   // ****************************************
   logic [BW-1:0] backlog_q;
   logic motion_mode;
   logic backlog_clear;
   logic enc_pulse_q;
   logic enc_forward_q;

   assign motion_mode = (enc_pulse_condition_select == qenc_pkg::MOTION_MODE);
   assign backlog_clear = (backlog_q == '0);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         backlog_q <= '0;
      end else if (motion_mode) begin
         backlog_q <= '0;
      end else if (step_valid && !step_fwd && backlog_q != '1) begin
         backlog_q <= backlog_q + BW'(1); // R03
      end else if (step_valid && step_fwd && !backlog_clear) begin
         backlog_q <= backlog_q - BW'(1); // R03
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         enc_pulse_q <= qenc_pkg::PULSE_RST;
      end else if (motion_mode) begin
         enc_pulse_q <= step_valid; // R01 R04
      end else begin
         enc_pulse_q <= step_valid & step_fwd & backlog_clear; // R01 R02 R03
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         enc_forward_q <= qenc_pkg::FWD_RST;
      end else if (step_valid) begin
         enc_forward_q <= step_fwd;
      end
   end

   assign enc_pulse = enc_pulse_q;
   assign enc_forward = enc_forward_q;
   assign backlog_count = backlog_q;

   // ****************************************
   // Rate scaling
   // ****************************************
   pulse_rate_scaler #(
      .FW(FW),
      .PW(PW)
   ) u_scale (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .pulse_in(enc_pulse_q),
      .pulse_rate_mul_factor(pulse_rate_mul_factor),
      .pulse_rate_div_factor(pulse_rate_div_factor),
      .scale_order_select(scale_order_select),
      .pulse_out(trigger_pulse)
   );

   // ****************************************
   // Selected line status
   // ****************************************
   logic line_level_q;
   logic line_input_q;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         line_level_q <= qenc_pkg::PULSE_RST;
         line_input_q <= qenc_pkg::PULSE_RST;
      end else if (io_line_index <= qenc_pkg::IO_PIN_SIX) begin
         line_level_q <= io_line_in[io_line_index]; // R15
         line_input_q <= (io_line_direction[io_line_index] == qenc_pkg::LINE_IS_INPUT); // R15
      end else begin
         line_level_q <= 1'h0;
         line_input_q <= 1'h0;
      end
   end

   assign line_level_sel = line_level_q;
   assign line_is_input_sel = line_input_q;

   // ****************************************
   // Checks
   // ****************************************
   sequence a_pin_one_steady_s;
      (phase_a_line_select == qenc_pkg::A_FROM_PIN_ONE
       && io_line_direction[qenc_pkg::IO_PIN_ONE] && io_line_in[qenc_pkg::IO_PIN_ONE]) [*3];
   endsequence

   sequence b_unused_steady_s;
      (phase_b_line_select == qenc_pkg::B_UNUSED) [*3];
   endsequence

   a_source_sel_a: assert property (a_pin_one_steady_s |-> a_s) // R10
      else $error("phase A does not follow pin one");

   b_unused_sel_a: assert property (b_unused_steady_s |-> !b_s) // R11
      else $error("unused phase B not held low");

   pos_forward_a: assert property (!motion_mode && step_valid && step_fwd && backlog_clear // R02
      |=> enc_pulse && backlog_q == '0)
      else $error("forward step with clear backlog gave no pulse");

   pos_reverse_a: assert property (!motion_mode && step_valid && !step_fwd // R03
      && backlog_q != '1 |=> !enc_pulse && backlog_q == $past(backlog_q) + BW'(1))
      else $error("reverse step not held back");

   motion_any_a: assert property (motion_mode && step_valid |=> enc_pulse) // R04
      else $error("motion step gave no pulse");

   rise_only_a: assert property (count_edge_select == qenc_pkg::EDGE_UP_ONLY // R13
      && !a_s && a_d_q |-> !step_valid)
      else $error("falling edge counted in rising mode");

   any_edge_a: assert property (count_edge_select == qenc_pkg::EDGE_BOTH // R14
      && a_s != a_d_q && !b_edge |-> step_valid)
      else $error("edge missed in both-edge mode");

   cw_dir_a: assert property (b_used && forward_phase_select == qenc_pkg::FWD_CLOCKWISE // R08
      && count_edge_select == qenc_pkg::EDGE_UP_ONLY && a_rise && b_s |-> step_fwd)
      else $error("clockwise direction wrong");

   ccw_dir_a: assert property (b_used && forward_phase_select == qenc_pkg::FWD_COUNTER_CLOCKWISE // R09
      && count_edge_select == qenc_pkg::EDGE_UP_ONLY && a_rise && !b_s |-> step_fwd)
      else $error("counter-clockwise direction wrong");

   no_b_fwd_a: assert property (!b_used && step_valid |-> step_fwd) // R16
      else $error("single phase step not forward");

   sync_lag_a: assert property (a_rise |-> $past(a_raw, 2) && !$past(a_raw, 3)) // R17
      else $error("phase A edge not two stages late");

endmodule : quadrature_encoder_trigger_rescaler

`default_nettype wire

/* tb/encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none

module encoder_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic step_req,
   input wire logic step_rev,
   output logic phase_a,
   output logic phase_b
);
   logic [1:0] pos_q;

   // Counting up lets phase B lead phase A, counting down lets A lead B
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_q <= 2'h0;
      end else if (step_req) begin
         pos_q <= step_rev ? pos_q - 2'h1 : pos_q + 2'h1;
      end
   end

   assign phase_a = pos_q[1];
   assign phase_b = pos_q[1] ^ pos_q[0];
endmodule : encoder_model

`default_nettype wire

/* tb/quadrature_encoder_trigger_rescaler_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module quadrature_encoder_trigger_rescaler_bench;
   logic sys_clk, arst_n, mode, order, fps, a_sel, edge_sel, req, rev, blind, exp_fwd;
   logic ph_a, ph_b, trig, encp, efwd, lvl, isin;
   logic [1:0] b_sel, pos;
   logic [2:0] idx;
   logic [7:0] mul, dvd;
   logic [5:0] dir_in, noise_q, lines;
   logic [15:0] backlog;
   logic [31:0] seed = 32'h7E707DDE;
   logic [31:0] rnd, r;
   int bad_count = 0;
   int tests_run = 0;
   int trig_seen, enc_seen, exp_enc, exp_bl, exp_trig, w, nst;

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Phase lines replace the selected pins, the rest carry noise
   always_comb begin
      lines = noise_q;
      lines[a_sel ? 2 : 0] = ph_a;
      if (b_sel == qenc_pkg::B_FROM_PIN_TWO) lines[1] = ph_b;
      else if (b_sel == qenc_pkg::B_FROM_PIN_FOUR) lines[3] = ph_b;
   end

   quadrature_encoder_trigger_rescaler DUT (
      .sys_clk(sys_clk), .arst_n(arst_n), .io_line_in(lines), .io_line_direction(dir_in),
      .io_line_index(idx), .enc_pulse_condition_select(mode), .scale_order_select(order),
      .pulse_rate_mul_factor(mul), .pulse_rate_div_factor(dvd), .forward_phase_select(fps),
      .phase_a_line_select(a_sel), .phase_b_line_select(b_sel), .count_edge_select(edge_sel),
      .trigger_pulse(trig), .enc_pulse(encp), .enc_forward(efwd), .backlog_count(backlog),
      .line_level_sel(lvl), .line_is_input_sel(isin));

   encoder_model ENC (.sys_clk(sys_clk), .arst_n(arst_n), .step_req(req), .step_rev(rev),
      .phase_a(ph_a), .phase_b(ph_b));

   always @(posedge sys_clk) begin
      if (trig === 1'b1) trig_seen++;
      if (encp === 1'b1) enc_seen++;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // Expected trigger count from the encoder pulse count and the rescaler setup
   function automatic int scaled_count(input int n, input logic [7:0] m, input logic [7:0] d,
                                       input logic ord);
      int mf;
      int df;
      mf = (m == 8'h00) ? 1 : int'(m);
      df = (d == 8'h00) ? 1 : int'(d);
      return (ord == qenc_pkg::MUL_THEN_DIV) ? n * mf / df : n / df * mf;
   endfunction : scaled_count

   task check(input logic [31:0] seen, input logic [31:0] expd, input string what);
      tests_run++;
      if (seen !== expd) begin
         bad_count++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, expd);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task reset_dut;
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      trig_seen = 0;
      enc_seen = 0;
      exp_enc = 0;
      exp_bl = 0;
      exp_fwd = 1'b1;
      pos = 2'h0;
      arst_n <= 1'b1;
   endtask : reset_dut

   // One encoder step; the expectation follows the configured counting rules
   task do_step(input logic rv);
      logic [1:0] np;
      logic a_ch, b_ch, fw, cnt;
      logic [31:0] t;
      np = rv ? pos - 2'h1 : pos + 2'h1;
      a_ch = np[1] != pos[1];
      b_ch = (np[1] ^ np[0]) != (pos[1] ^ pos[0]);
      fw = (b_sel inside {2'h1, 2'h2}) ? ((fps == qenc_pkg::FWD_CLOCKWISE) ? !rv : rv) : 1'b1;
      cnt = (edge_sel == qenc_pkg::EDGE_BOTH) ? (a_ch || (b_ch && b_sel inside {2'h1, 2'h2}))
            : (a_ch && np[1]);
      if (cnt && !blind) begin
         exp_fwd = fw;
         if (mode == qenc_pkg::MOTION_MODE) exp_enc++;
         else if (!fw) exp_bl++;
         else if (exp_bl > 0) exp_bl--;
         else exp_enc++;
      end
      pos = np;
      t = xs();
      @(posedge sys_clk);
      req <= 1'b1;
      rev <= rv;
      noise_q <= t[5:0];
      @(posedge sys_clk);
      req <= 1'b0;
      repeat (t[9:8]) @(posedge sys_clk);
   endtask : do_step

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      arst_n = 1'b0;
      {req, rev, mode, order, fps, a_sel, edge_sel, blind} = 8'h00;
      b_sel = 2'h0;
      idx = 3'h0;
      mul = 8'h01;
      dvd = 8'h01;
      dir_in = 6'h3F;
      noise_q = 6'h00;
      for (int s = 0; s < 16; s++) begin
         r = xs();
         // Scenarios 2 to 9 walk every mode, order, edge and phase B code
         if (s >= 2 && s < 10) r[6:0] = {s[2], s[1:0], s[2] ^ s[0], s[1] ^ s[2], s[1], s[0]};
         reset_dut;
         blind = (s == 1);
         @(posedge sys_clk);
         mode <= (s == 0) ? qenc_pkg::POSITION_MODE : r[0];
         edge_sel <= (s == 0) ? qenc_pkg::EDGE_BOTH : r[6];
         b_sel <= (s == 0) ? qenc_pkg::B_FROM_PIN_TWO : (s == 1) ? qenc_pkg::B_UNUSED : r[5:4];
         fps <= r[2];
         order <= r[1];
         a_sel <= r[3];
         mul <= {5'h00, r[10:8]};
         dvd <= {5'h00, r[13:11]};
         dir_in <= (s == 1) ? (r[3] ? 6'h3B : 6'h3E) : 6'h3F;
         @(posedge sys_clk);
         if (s == 0) begin
            repeat (5) do_step(1'b0);
            repeat (3) do_step(1'b1);
            repeat (6) do_step(1'b0);
         end else begin
            nst = 6 + int'(r[20:16]);
            for (int k = 0; k < nst; k++) begin
               rnd = xs();
               do_step(rnd[0] & rnd[1]);
            end
         end
         exp_trig = scaled_count(exp_enc, mul, dvd, order);
         for (w = 0; w < 3000 && (trig_seen < exp_trig || enc_seen < exp_enc); w++) begin
            @(posedge sys_clk);
         end
         if (w == 3000) begin
            bad_count++;
            tally_and_finish;
         end
         repeat (30) @(posedge sys_clk);
         check(enc_seen, exp_enc, "encoder pulses");
         check(trig_seen, exp_trig, "trigger pulses");
         check({16'h0000, backlog}, exp_bl, "backlog");
         check({31'h0, efwd}, {31'h0, exp_fwd}, "direction");
      end
      for (int i = 0; i < 8; i++) begin
         rnd = xs();
         @(posedge sys_clk);
         idx <= 3'(i);
         dir_in <= rnd[5:0];
         noise_q <= rnd[13:8];
         repeat (2) @(posedge sys_clk);
         if (i < 6) begin
            check({31'h0, isin}, {31'h0, dir_in[i]}, "line direction");
            if (dir_in[i]) check({31'h0, lvl}, {31'h0, lines[i]}, "line level");
         end else begin
            check({30'h0, isin, lvl}, 32'h0, "spare index");
         end
      end
      tally_and_finish;
   end
endmodule : quadrature_encoder_trigger_rescaler_bench

`default_nettype wire
